// >>> mpmi_params.svh
`ifndef MPMI_PARAMS_SVH
`define MPMI_PARAMS_SVH
// ************************************************************
// clock and timing
// ************************************************************
`define MPMI_CLK_HZ 20000000
`define MPMI_MDC_MAX_HZ 2500000
`define MPMI_TXCLK_10M_HZ 2500000
`define MPMI_TXCLK_100M_HZ 25000000
// ************************************************************
// frame format
// ************************************************************
`define MPMI_PREAMBLE 64'hD555555555555555
`define MPMI_PRE_BITS 7'd64
`define MPMI_MII_SFD 4'hD
`define MPMI_RMII_SFD 2'h3
`define MPMI_CRC_INIT 32'hFFFFFFFF
`define MPMI_CRC_POLY 32'hEDB88320
`define MPMI_CRC_RESIDUE 32'hDEBB20E3
`define MPMI_MIN_BITS 14'h0200
`define MPMI_MAX_BITS 14'h2F70
`define MPMI_BITS_SAT 14'h3FFF
// ************************************************************
// management frame
// ************************************************************
`define MPMI_MD_BITS 7'd64
`define MPMI_MD_TA_BIT 7'd46
`define MPMI_MD_DATA_BIT 7'd48
`define MPMI_MD_OP_WR 2'h1
`define MPMI_MD_OP_RD 2'h2
`endif

// >>> mpmi_pkg.sv
package mpmi_pkg;
    typedef struct packed {
        logic last;
        logic [1:0] nbytes_m1;
        logic [31:0] data;
    } mpmi_word_s;
    typedef struct packed {
        logic bad;
        mpmi_word_s w;
    } mpmi_rx_word_s;
    typedef struct packed {
        logic write;
        logic [4:0] phy;
        logic [4:0] regad;
        logic [15:0] wdata;
    } mpmi_mgmt_cmd_s;
    typedef enum logic [1:0] {
        MPMI_TX_IDLE = 2'b00,
        MPMI_TX_PRE = 2'b01,
        MPMI_TX_DATA = 2'b10,
        MPMI_TX_DROP = 2'b11
    } mpmi_tx_state_e;
    typedef enum logic [1:0] {
        MPMI_RX_IDLE = 2'b00,
        MPMI_RX_SFD = 2'b01,
        MPMI_RX_DATA = 2'b10,
        MPMI_RX_FLUSH = 2'b11
    } mpmi_rx_state_e;
endpackage

// >>> mpmi_top.sv
// Behaviour
// - separate 32-bit transmit and receive FIFOs with valid/ready handshake
// - frame data crosses safely between application and link timing
// - transmit nibble clock from the internal divider: 2.5 MHz at 10 Mbit/s, 10 MHz at 100
// - transmit clock from internal divider, external oscillator or, in reduced mode, the receive clock
// - transmit nibbles leave least significant bit first
// - transmit data only meaningful while transmit enable is high
// - transmit enable rises with first preamble nibble, holds to frame end
// - receive error without data valid is status, never frame data
// - carrier sense asynchronous; ignored in full duplex
// - collision ignored in full duplex, taken asynchronously
// - reduced mode: independent two-bit transmit and receive paths
// - management clock divided from system clock, at most 2.5 MHz
// - management data driven on management clock by sending side
// - independent transmit and receive data movers toward memory
// - completion and error events raise interrupts under enable
// - frame bad on CRC, runt, alignment, oversize or receive error
`timescale 1ns/100ps
`include "mpmi_params.svh"

// ************************************************************
// shift-register FIFO: head always sits in entry 0
// ************************************************************
module mpmi_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // drain side
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int CW = $clog2(DEPTH + 1);
    logic [W-1:0] mem_r [DEPTH];
    logic [W-1:0] mem_nxt [DEPTH];
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic rdy_r, rdy_nxt, vld_r, vld_nxt;
    logic push, pop;

    assign push = in_valid && rdy_r;
    assign pop = out_ready && vld_r;
    assign in_ready = rdy_r;
    assign out_valid = vld_r;
    assign out_data = mem_r[0];

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_ent
            always_comb begin
                mem_nxt[i] = mem_r[i];
                if (pop) begin
                    if (i < DEPTH - 1)
                        mem_nxt[i] = mem_r[i+1];
                    if (push && i == int'(cnt_r) - 1)
                        mem_nxt[i] = in_data;
                end else if (push && i == int'(cnt_r)) begin
                    mem_nxt[i] = in_data;
                end
            end
            always_ff @(posedge clk or posedge rst) begin
                if (rst)
                    mem_r[i] <= '0;
                else
                    mem_r[i] <= mem_nxt[i];
            end
        end
    endgenerate

    always_comb begin
        cnt_nxt = cnt_r + CW'(push) - CW'(pop);
        rdy_nxt = (cnt_nxt != CW'(DEPTH));
        vld_nxt = (cnt_nxt != '0);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            rdy_r <= 1'b1;
            vld_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            rdy_r <= rdy_nxt;
            vld_r <= vld_nxt;
        end
    end
endmodule // mpmi_fifo

// ************************************************************
// media interface top
// ************************************************************
module mpmi_top import mpmi_pkg::*; #(
    parameter int TX_DEPTH = 8,
    parameter int RX_DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // mode
    input wire logic rmii_mode,
    input wire logic speed_100,
    input wire logic tx_clk_ext_sel,
    input wire logic full_duplex,
    input wire logic [2:0] irq_enable,
    // transmit words from memory
    input wire mpmi_word_s tx_word,
    input wire logic tx_word_valid,
    output logic tx_word_ready,
    // receive words to memory
    output mpmi_rx_word_s rx_word,
    output logic rx_word_valid,
    input wire logic rx_word_ready,
    // transmit pins
    input wire logic tx_clk_osc,
    output logic tx_nibble_clk,
    output logic [3:0] txd,
    output logic tx_en,
    // receive pins
    input wire logic rx_clk_in,
    input wire logic [3:0] rxd,
    input wire logic rx_data_valid,
    input wire logic rx_error_in,
    input wire logic carrier_sense_in,
    input wire logic collision_in,
    // station management port
    input wire logic mgmt_start,
    input wire mpmi_mgmt_cmd_s mgmt_cmd,
    output logic mgmt_busy,
    output logic [15:0] mgmt_rdata,
    output logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    // events
    output logic tx_done_irq,
    output logic rx_done_irq,
    output logic error_irq
);
    localparam int CLK_HZ = `MPMI_CLK_HZ;
    localparam int MDC_HALF = (CLK_HZ + 2 * `MPMI_MDC_MAX_HZ - 1) /
        (2 * `MPMI_MDC_MAX_HZ);
    localparam int TXH_10 = (CLK_HZ + 2 * `MPMI_TXCLK_10M_HZ - 1) /
        (2 * `MPMI_TXCLK_10M_HZ);
    localparam int TXH_100 = (CLK_HZ + 2 * `MPMI_TXCLK_100M_HZ - 1) /
        (2 * `MPMI_TXCLK_100M_HZ);

    function automatic logic [31:0] crc_step(input logic [31:0] c,
            input logic [3:0] d, input logic [2:0] n);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 4; i++) begin
            if (i < int'(n))
                r = (r >> 1) ^ ((r[0] ^ d[i]) ? `MPMI_CRC_POLY : 32'h0);
        end
        return r;
    endfunction

    // ********************************************************
    // synchronisers
    // ********************************************************
    // only the second stage and the clock history flops are read
    logic [9:0] s1_r, s2_r;
    logic [1:0] s3_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= {rx_clk_in, tx_clk_osc, carrier_sense_in,
                collision_in, rx_data_valid, rx_error_in, rxd};
            s2_r <= s1_r;
            s3_r <= s2_r[9:8];
        end
    end
    logic rxc_rise, osc_fall, crs_s, col_s, dv_s, er_s;
    logic [3:0] rxd_s;
    logic [2:0] uw;
    assign rxc_rise = s2_r[9] && !s3_r[1];
    assign osc_fall = !s2_r[8] && s3_r[0];
    assign crs_s = s2_r[7] && !full_duplex;
    assign col_s = s2_r[6] && !full_duplex;
    assign dv_s = s2_r[5];
    assign er_s = s2_r[4];
    assign rxd_s = s2_r[3:0];
    assign uw = rmii_mode ? 3'd2 : 3'd4;

    // ********************************************************
    // fifos
    // ********************************************************
    mpmi_word_s txf_out;
    logic txf_valid, txf_pop;
    mpmi_rx_word_s rxf_in;
    logic rxf_push, rxf_ready;
    mpmi_fifo #(.W($bits(mpmi_word_s)), .DEPTH(TX_DEPTH)) u_txf (
        .clk(clk), .rst(rst),
        .in_data(tx_word), .in_valid(tx_word_valid),
        .in_ready(tx_word_ready),
        .out_data(txf_out), .out_valid(txf_valid), .out_ready(txf_pop));
    mpmi_fifo #(.W($bits(mpmi_rx_word_s)), .DEPTH(RX_DEPTH)) u_rxf (
        .clk(clk), .rst(rst),
        .in_data(rxf_in), .in_valid(rxf_push), .in_ready(rxf_ready),
        .out_data(rx_word), .out_valid(rx_word_valid),
        .out_ready(rx_word_ready));

    // ********************************************************
    // transmit
    // ********************************************************
    mpmi_tx_state_e tx_st_r, tx_st_nxt;
    logic [63:0] sh_r, sh_nxt;
    logic [6:0] bits_r, bits_nxt;
    logic [7:0] hc_r, hc_nxt;
    logic tclk_r, tclk_nxt, tlast_r, tlast_nxt, ten_r, ten_nxt;
    logic [3:0] txd_r, txd_nxt;
    logic tdone, terr, ttick;
    always_comb begin
        tx_st_nxt = tx_st_r;
        sh_nxt = sh_r;
        bits_nxt = bits_r;
        hc_nxt = hc_r;
        tclk_nxt = tclk_r;
        tlast_nxt = tlast_r;
        ten_nxt = ten_r;
        txd_nxt = txd_r;
        txf_pop = 1'b0;
        tdone = 1'b0;
        terr = 1'b0;
        ttick = 1'b0;
        if (rmii_mode || tx_clk_ext_sel) begin
            tclk_nxt = rmii_mode ? s2_r[9] : s2_r[8];
            ttick = rmii_mode ? !s2_r[9] && s3_r[1] : osc_fall;
            hc_nxt = '0;
        end else if (hc_r == '0) begin
            hc_nxt = 8'(speed_100 ? TXH_100 - 1 : TXH_10 - 1);
            tclk_nxt = !tclk_r;
            ttick = tclk_r;
        end else begin
            hc_nxt = hc_r - 8'h01;
        end
        case (tx_st_r)
            MPMI_TX_IDLE: begin
                if (ttick) begin
                    ten_nxt = 1'b0;
                    if (txf_valid && !crs_s) begin
                        sh_nxt = `MPMI_PREAMBLE;
                        bits_nxt = `MPMI_PRE_BITS;
                        tx_st_nxt = MPMI_TX_PRE;
                    end
                end
            end
            MPMI_TX_PRE, MPMI_TX_DATA: begin
                if (ttick && col_s) begin
                    ten_nxt = 1'b0;
                    terr = 1'b1;
                    tx_st_nxt = (tx_st_r == MPMI_TX_DATA && tlast_r) ?
                        MPMI_TX_IDLE : MPMI_TX_DROP;
                end else if (ttick) begin
                    ten_nxt = 1'b1;
                    txd_nxt = rmii_mode ? {2'h0, sh_r[1:0]} : sh_r[3:0];
                    sh_nxt = sh_r >> uw;
                    bits_nxt = bits_r - 7'(uw);
                    if (bits_r == 7'(uw)) begin
                        if (tx_st_r == MPMI_TX_DATA && tlast_r) begin
                            tdone = 1'b1;
                            tx_st_nxt = MPMI_TX_IDLE;
                        end else if (txf_valid) begin
                            txf_pop = 1'b1;
                            sh_nxt = {32'h0, txf_out.data};
                            bits_nxt = {2'h0, txf_out.nbytes_m1 + 2'h1, 3'h0}
                                + (txf_out.nbytes_m1 == 2'h3 ? 7'h20 : 7'h0);
                            tlast_nxt = txf_out.last;
                            tx_st_nxt = MPMI_TX_DATA;
                        end else begin
                            terr = 1'b1;
                            tx_st_nxt = MPMI_TX_DROP;
                        end
                    end
                end
            end
            MPMI_TX_DROP: begin
                if (ttick)
                    ten_nxt = 1'b0;
                if (txf_valid) begin
                    txf_pop = 1'b1;
                    if (txf_out.last)
                        tx_st_nxt = MPMI_TX_IDLE;
                end
            end
            default: tx_st_nxt = MPMI_TX_IDLE;
        endcase
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_st_r <= MPMI_TX_IDLE;
            sh_r <= '0;
            bits_r <= '0;
            hc_r <= '0;
            tclk_r <= 1'b0;
            tlast_r <= 1'b0;
            ten_r <= 1'b0;
            txd_r <= '0;
        end else begin
            tx_st_r <= tx_st_nxt;
            sh_r <= sh_nxt;
            bits_r <= bits_nxt;
            hc_r <= hc_nxt;
            tclk_r <= tclk_nxt;
            tlast_r <= tlast_nxt;
            ten_r <= ten_nxt;
            txd_r <= txd_nxt;
        end
    end
    assign tx_nibble_clk = tclk_r;
    assign tx_en = ten_r;
    assign txd = txd_r;

    // ********************************************************
    // receive
    // ********************************************************
    mpmi_rx_state_e rx_st_r, rx_st_nxt;
    logic [31:0] acc_r, acc_nxt, crc_r, crc_nxt;
    logic [5:0] bc_r, bc_nxt;
    logic [13:0] tot_r, tot_nxt;
    mpmi_word_s pend_r, pend_nxt;
    logic pv_r, pv_nxt, ers_r, ers_nxt, ovf_r, ovf_nxt, rdone;
    logic sfd, bad;
    always_comb begin
        rx_st_nxt = rx_st_r;
        acc_nxt = acc_r;
        crc_nxt = crc_r;
        bc_nxt = bc_r;
        tot_nxt = tot_r;
        pend_nxt = pend_r;
        pv_nxt = pv_r;
        ers_nxt = ers_r;
        ovf_nxt = ovf_r;
        rdone = 1'b0;
        rxf_push = 1'b0;
        rxf_in = '0;
        sfd = rmii_mode ? (rxd_s[1:0] == `MPMI_RMII_SFD)
            : (rxd_s == `MPMI_MII_SFD);
        bad = ers_r || ovf_r || bc_r[2:0] != 3'h0
            || crc_r != `MPMI_CRC_RESIDUE || tot_r < `MPMI_MIN_BITS
            || tot_r > `MPMI_MAX_BITS;
        case (rx_st_r)
            MPMI_RX_IDLE: begin
                if (rxc_rise && dv_s) begin
                    acc_nxt = '0;
                    crc_nxt = `MPMI_CRC_INIT;
                    bc_nxt = '0;
                    tot_nxt = '0;
                    ovf_nxt = 1'b0;
                    ers_nxt = er_s;
                    rx_st_nxt = sfd ? MPMI_RX_DATA : MPMI_RX_SFD;
                end
            end
            MPMI_RX_SFD: begin
                if (rxc_rise) begin
                    ers_nxt = ers_r || (dv_s && er_s);
                    if (!dv_s)
                        rx_st_nxt = MPMI_RX_IDLE;
                    else if (sfd)
                        rx_st_nxt = MPMI_RX_DATA;
                end
            end
            MPMI_RX_DATA: begin
                if (rxc_rise && !dv_s) begin
                    rx_st_nxt = MPMI_RX_FLUSH;
                end else if (rxc_rise) begin
                    ers_nxt = ers_r || er_s;
                    acc_nxt = rmii_mode ? {rxd_s[1:0], acc_r[31:2]}
                        : {rxd_s, acc_r[31:4]};
                    crc_nxt = crc_step(crc_r, rxd_s, uw);
                    tot_nxt = (tot_r == `MPMI_BITS_SAT) ? tot_r
                        : tot_r + 14'(uw);
                    bc_nxt = bc_r + 6'(uw);
                    if (bc_nxt == 6'h20) begin
                        bc_nxt = '0;
                        if (pv_r) begin
                            rxf_push = 1'b1;
                            rxf_in = {1'b0, pend_r};
                            ovf_nxt = ovf_r || !rxf_ready;
                        end
                        pend_nxt = {1'b0, 2'h3, acc_nxt};
                        pv_nxt = 1'b1;
                    end
                end
            end
            MPMI_RX_FLUSH: begin
                if (pv_r) begin
                    rxf_push = 1'b1;
                    rxf_in = {bad, pend_r.last, pend_r.nbytes_m1,
                        pend_r.data};
                    rxf_in.w.last = (bc_r < 6'h08);
                    rxf_in.bad = bad && rxf_in.w.last;
                    if (rxf_ready)
                        pv_nxt = 1'b0;
                end else if (bc_r >= 6'h08) begin
                    rxf_push = 1'b1;
                    rxf_in.bad = bad;
                    rxf_in.w.last = 1'b1;
                    rxf_in.w.nbytes_m1 = 2'(bc_r[4:3] - 2'h1);
                    rxf_in.w.data = acc_r >> (6'h20 - bc_r);
                    if (rxf_ready)
                        bc_nxt = {3'h0, bc_r[2:0]};
                end else begin
                    rdone = (tot_r != '0);
                    rx_st_nxt = MPMI_RX_IDLE;
                end
            end
            default: rx_st_nxt = MPMI_RX_IDLE;
        endcase
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_st_r <= MPMI_RX_IDLE;
            acc_r <= '0;
            crc_r <= '0;
            bc_r <= '0;
            tot_r <= '0;
            pend_r <= '0;
            pv_r <= 1'b0;
            ers_r <= 1'b0;
            ovf_r <= 1'b0;
        end else begin
            rx_st_r <= rx_st_nxt;
            acc_r <= acc_nxt;
            crc_r <= crc_nxt;
            bc_r <= bc_nxt;
            tot_r <= tot_nxt;
            pend_r <= pend_nxt;
            pv_r <= pv_nxt;
            ers_r <= ers_nxt;
            ovf_r <= ovf_nxt;
        end
    end

    // ********************************************************
    // station management and events
    // ********************************************************
    logic [63:0] md_r, md_nxt;
    logic [6:0] mi_r, mi_nxt;
    logic [3:0] mh_r, mh_nxt;
    logic mb_r, mb_nxt, mc_r, mc_nxt, mo_r, mo_nxt, me_r, me_nxt, mw_r, mw_nxt;
    logic [15:0] rd_r, rd_nxt;
    logic [2:0] ev_r, ev_nxt;
    always_comb begin
        md_nxt = md_r;
        mi_nxt = mi_r;
        mh_nxt = mh_r;
        mb_nxt = mb_r;
        mc_nxt = mc_r;
        mo_nxt = mo_r;
        me_nxt = me_r;
        mw_nxt = mw_r;
        rd_nxt = rd_r;
        ev_nxt = irq_enable & {rdone && bad || terr, rdone, tdone};
        if (!mb_r) begin
            if (mgmt_start) begin
                md_nxt = {32'hFFFFFFFF, 2'h1, mgmt_cmd.write ?
                    `MPMI_MD_OP_WR : `MPMI_MD_OP_RD, mgmt_cmd.phy,
                    mgmt_cmd.regad, 2'h2, mgmt_cmd.wdata};
                mw_nxt = mgmt_cmd.write;
                mb_nxt = 1'b1;
                mi_nxt = '0;
                mh_nxt = 4'(MDC_HALF - 1);
                mo_nxt = 1'b1;
                me_nxt = 1'b1;
            end
        end else if (mh_r != '0) begin
            mh_nxt = mh_r - 4'h1;
        end else begin
            mh_nxt = 4'(MDC_HALF - 1);
            mc_nxt = !mc_r;
            if (!mc_r) begin
                if (!mw_r && mi_r >= `MPMI_MD_DATA_BIT)
                    rd_nxt = {rd_r[14:0], mdio_in};
            end else if (mi_r == `MPMI_MD_BITS - 7'd1) begin
                mb_nxt = 1'b0;
                me_nxt = 1'b0;
            end else begin
                mi_nxt = mi_r + 7'd1;
                md_nxt = md_r << 1;
                mo_nxt = md_r[62];
                me_nxt = mw_r || (mi_nxt < `MPMI_MD_TA_BIT);
            end
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            md_r <= '0;
            mi_r <= '0;
            mh_r <= '0;
            mb_r <= 1'b0;
            mc_r <= 1'b0;
            mo_r <= 1'b0;
            me_r <= 1'b0;
            mw_r <= 1'b0;
            rd_r <= '0;
            ev_r <= '0;
        end else begin
            md_r <= md_nxt;
            mi_r <= mi_nxt;
            mh_r <= mh_nxt;
            mb_r <= mb_nxt;
            mc_r <= mc_nxt;
            mo_r <= mo_nxt;
            me_r <= me_nxt;
            mw_r <= mw_nxt;
            rd_r <= rd_nxt;
            ev_r <= ev_nxt;
        end
    end
    assign mgmt_busy = mb_r;
    assign mgmt_rdata = rd_r;
    assign mdc = mc_r;
    assign mdio_out = mo_r;
    assign mdio_oe = me_r;
    assign {error_irq, rx_done_irq, tx_done_irq} = ev_r;
endmodule // mpmi_top

// >>> mpmi_top_monitor.sv
`timescale 1ns/100ps
module mpmi_top_monitor import mpmi_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // watched ports
    input wire logic rmii_mode,
    input wire logic [2:0] irq_enable,
    input wire logic tx_done_irq,
    input wire logic rx_done_irq,
    input wire logic error_irq,
    input wire logic tx_nibble_clk,
    input wire logic [3:0] txd,
    input wire logic tx_en,
    input wire mpmi_rx_word_s rx_word,
    input wire logic rx_word_valid,
    input wire logic rx_word_ready,
    input wire logic mgmt_start,
    input wire logic mgmt_busy,
    input wire logic mdc,
    input wire logic mdio_oe
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    property p_pre;
        $rose(tx_en) |-> txd[1:0] == 2'h1 && (rmii_mode || txd[3:2] == 2'h1);
    endproperty
    a_pre: assert property (p_pre) else $error("no preamble");
    // units launch on the falling edge, so nothing moves while it is high
    property p_hold;
        tx_nibble_clk && $past(tx_nibble_clk) |-> $stable({txd, tx_en});
    endproperty
    a_hold: assert property (p_hold) else $error("unit moved");
    property p_irq_tx;
        tx_done_irq |-> irq_enable[0] ##1 !tx_done_irq;
    endproperty
    a_irq_tx: assert property (p_irq_tx) else $error("tx event");
    property p_irq_rx;
        rx_done_irq |-> irq_enable[1] ##1 !rx_done_irq;
    endproperty
    a_irq_rx: assert property (p_irq_rx) else $error("rx event");
    property p_irq_err;
        error_irq |-> irq_enable[2];
    endproperty
    a_irq_err: assert property (p_irq_err) else $error("error event");
    property p_rx_hold;
        rx_word_valid && !rx_word_ready |=> rx_word_valid && $stable(rx_word);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx word lost");
    property p_take;
        mgmt_start && !mgmt_busy |=> mgmt_busy && mdio_oe;
    endproperty
    a_take: assert property (p_take) else $error("mgmt not taken");
    property p_oe;
        mdio_oe |-> mgmt_busy;
    endproperty
    a_oe: assert property (p_oe) else $error("mdio driven idle");
    property p_mdc;
        $rose(mdc) |-> mdc[*4] ##1 !mdc;
    endproperty
    a_mdc: assert property (p_mdc) else $error("mdc too fast");
    c_tx: cover property ($fell(tx_en));
    c_rx: cover property (rx_word_valid && rx_word.bad);
    c_md: cover property ($fell(mgmt_busy));
endmodule // mpmi_top_monitor

// >>> mpmi_phy_model.sv
`timescale 1ns/100ps
module mpmi_phy_model (
    // transmit pins
    input wire logic tx_nibble_clk,
    input wire logic [3:0] txd,
    input wire logic tx_en,
    input wire logic rmii_mode,
    // receive pins
    output logic rx_clk_in,
    output logic [3:0] rxd,
    output logic rx_data_valid,
    // management wire
    input wire logic mdc,
    input wire logic mdio_in,
    input wire logic mdio_oe,
    output logic phy_oe,
    output logic phy_do
);
    logic [3:0] tx_q[$];
    logic [63:0] md_bits = 64'h0;
    logic [15:0] rd_val = 16'h0;
    int md_n = 0;
    initial {rx_clk_in, rxd, rx_data_valid, phy_oe, phy_do} = 8'h0;
    // the rising edge sees the unit settled since the falling edge
    always @(posedge tx_nibble_clk) begin
        if (tx_en) tx_q.push_back(rmii_mode ? {2'h0, txd[1:0]} : txd);
    end
    always @(posedge mdc) md_bits <= {md_bits[62:0], mdio_in};
    always @(posedge mdio_oe) md_n = 0;
    always @(negedge mdc) begin
        md_n++;
        phy_oe <= md_n >= 47 && md_n <= 63 && !mdio_oe;
        phy_do <= md_n == 47 ? 1'h0 : rd_val[63 - md_n];
    end
    // the reference runs free; released data is inverted
    always #200 rx_clk_in = ~rx_clk_in;
    task automatic play(input logic [3:0] u[$]);
        foreach (u[i]) begin
            @(negedge rx_clk_in);
            rxd = u[i];
            rx_data_valid = 1'h1;
        end
        @(negedge rx_clk_in);
        rxd = ~rxd;
        rx_data_valid = 1'h0;
        repeat (3) @(negedge rx_clk_in);
    endtask
endmodule // mpmi_phy_model

// >>> mpmi_top_tb.sv
`timescale 1ns/100ps
module mpmi_top_tb;
    import mpmi_pkg::*;
    logic clk = 1'h0, rst = 1'h1, tx_clk_ext_sel = 1'h0, tx_clk_osc = 1'h0;
    logic rx_error_in = 1'h0, collision_in = 1'h0, rmii_mode = 1'h0;
    logic speed_100 = 1'h0, full_duplex = 1'h1, tx_word_valid = 1'h0;
    logic rx_word_ready = 1'h0, mgmt_start = 1'h0;
    logic [2:0] irq_enable = 3'h7;
    mpmi_word_s tx_word = '0;
    mpmi_mgmt_cmd_s mgmt_cmd = '0;
    mpmi_rx_word_s rx_word;
    logic tx_word_ready, rx_word_valid, tx_nibble_clk, tx_en, rx_clk_in;
    logic rx_data_valid, mgmt_busy, mdc, mdio_out, mdio_oe, phy_oe, phy_do;
    logic tx_done_irq, rx_done_irq, error_irq;
    logic [3:0] txd, rxd;
    logic [15:0] mgmt_rdata;
    logic [31:0] seed = 32'hC5098324;
    int n_mismatch = 0, n_tests = 0;
    wire carrier_sense_in = rx_data_valid;
    // management wire has a pull-up
    wire mdio_in = mdio_oe ? mdio_out : (phy_oe ? phy_do : 1'h1);
    mpmi_top i_dut (.*);
    mpmi_phy_model i_phy (.*);
    always #25 clk = ~clk;
    always #150 tx_clk_osc = ~tx_clk_osc;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        if (n_mismatch == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
    initial begin
        logic [3:0] q[$];
        logic [31:0] d[2];
        logic [127:0] bits;
        logic [63:0] e;
        logic [3:0] u;
        int w;
        repeat (16) @(negedge clk);
        rst = 1'h0;
        // short last word, both widths
        for (int m = 0; m < 3; m++) begin
            d[0] = rnd();
            rmii_mode = m[0];
            tx_clk_ext_sel = m[1];
            {speed_100, full_duplex} = d[0][1:0];
            for (int i = 0; i < 2; i++) begin
                d[i] = rnd();
                tx_word = {i[0], i[0] ? 2'h1 : 2'h3, d[i]};
                tx_word_valid = 1'h1;
                while (!tx_word_ready) @(negedge clk);
                @(negedge clk);
            end
            tx_word_valid = 1'h0;
            while (!tx_en) @(negedge clk);
            while (tx_en) @(negedge clk);
            repeat (8) @(negedge clk);
            w = m[0] ? 2 : 4;
            bits = {16'h0, d[1][15:0], d[0], 64'hD555555555555555};
            check("tx count", i_phy.tx_q.size(), 112 / w);
            foreach (i_phy.tx_q[j]) begin
                u = bits[j * w +: 4] & (m[0] ? 4'h3 : 4'hF);
                check("tx unit", i_phy.tx_q[j], u);
            end
            i_phy.tx_q = {};
        end
        // eight bytes, reader stalled: a runt
        rmii_mode = 1'h0;
        d[0] = rnd();
        d[1] = rnd();
        bits = {d[1], d[0], 64'hD555555555555555};
        for (int j = 0; j < 32; j++) q.push_back(bits[j * 4 +: 4]);
        rx_error_in = 1'h1;
        i_phy.play(q);
        rx_error_in = 1'h0;
        for (int i = 0; i < 2; i++) begin
            while (!rx_word_valid) @(negedge clk);
            check("rx word", rx_word.w, {i[0], 2'h3, d[i]});
            if (i) check("rx bad", rx_word.bad, 1'h1);
            rx_word_ready = 1'h1;
            @(negedge clk);
            rx_word_ready = 1'h0;
        end
        // write, then read answered by the model
        for (int i = 0; i < 2; i++) begin
            d[0] = rnd();
            mgmt_cmd = {~i[0], d[0][9:0], d[0][31:16]};
            i_phy.rd_val = d[0][25:10];
            mgmt_start = 1'h1;
            @(negedge clk);
            mgmt_start = 1'h0;
            @(negedge clk);
            while (mgmt_busy) @(negedge clk);
            e = {32'hFFFFFFFF, i ? 4'h6 : 4'h5, d[0][9:0], 2'h2, 16'h0};
            e[15:0] = i ? d[0][25:10] : d[0][31:16];
            check("mgmt frame", i_phy.md_bits, e);
            if (i) check("mgmt read", mgmt_rdata, d[0][25:10]);
        end
        summarize();
    end
endmodule // mpmi_top_tb
bind mpmi_top mpmi_top_monitor i_mon (.*);
